// [shared/irq_pkg.sv]
// Purpose: constants and types for the interrupt handler with wake-up timer
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz aclk as undivided source clock
// Notes:   byte offsets are word aligned
package irq_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_PRIO_LOW  = 8'h04;
   localparam logic [7:0] OFS_PRIO_HIGH = 8'h08;
   localparam logic [7:0] OFS_EXT_EN    = 8'h0c;
   localparam logic [7:0] OFS_EXT_FLAG  = 8'h10;
   localparam logic [7:0] OFS_WAKE_CTL  = 8'h14;
   localparam logic [7:0] OFS_WAKE_CNT  = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1c;
   localparam logic [7:0] OFS_VEC_BASE  = 8'h20;
   // ==========================================
   // fields and reset values
   localparam int         CTRL_GIE      = 0;
   localparam int         CTRL_SLOW     = 1;
   localparam int         CTRL_CD_LSB   = 2;
   localparam int         WCTL_EN       = 0;
   localparam int         WCTL_FLAG     = 1;
   localparam logic [1:0] IPS_IDLE      = 2'h3;
   localparam logic [15:0] VECTOR_BASE  = 16'h0020;
   localparam int         VEC_STRIDE_SH = 3;
   localparam int         SRC_PFAIL     = 0;
   localparam int         SRC_EXT       = 2;
   localparam int         SRC_WAKE      = 7;
   localparam int         FILT_LEN      = 3;
   localparam logic [8:0] SLOW_RATIO    = 9'h100;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   // ==========================================
   // types
   typedef enum logic [1:0] {ST_IDLE, ST_STALL, ST_HOLD, ST_VEC} disp_state_t;
   typedef struct packed {
      logic        fetch_cancel;
      logic        push;
      logic        ip_load;
      logic [15:0] vector;
      logic        pop;
      logic        ip_from_stack;
   } cpu_cmd_t;
endpackage : irq_pkg

// [core/irq_handler.sv]
// Purpose: interrupt handler, async input filter and wake-up timer
// Assumes: aclk is the undivided source clock; system clock is a tick
// Notes:   cpu side works once per system tick
// Behaviour
// - wake timer counts ring oscillator cycles and keeps counting in stop mode
// - interval is ring period times 16-bit count, at most 65535 periods
// - wake needs its interrupt to fire; software sets global enable first
// - vector base fixed at 0020h, vectors at fixed offsets from it
// - global enable resets to 0 and masks all but power-fail
// - flags set on condition even when disabled; enables gate requests only; here the wake flag sets only while wake_en_q is on
// - three priority levels per source; level in service kept in state bits
// - requests sampled on clock edge, serviced one cycle later outside windows
// - window-opening instruction delays vectoring by one extra cycle
// - service cancels fetch, pushes return, sets level, loads vector
// - return pops address, sets active level to 11b, reloads pointer
// - no interrupt on return cycle; two cycles at least between interrupts
// - internal sources are synchronous and recognised within one cycle
// - external inputs pass three-clock filter on the undivided clock
// - async recognition three, two, one system clocks at ratios 1, 2, 4+
// - async pulses narrower than three undivided clocks are ignored
// - synchronous and filtered requests of one module merge into one line
// - enabled external interrupts switch back from slow mode at once
// - level 0 highest, 2 lowest; preempt only by strictly higher level
// - equal levels resolved by lowest natural source number
// - divide ratio 1, 2, 4, 8 by divide select while slow mode clear
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module irq_handler
   import irq_pkg::*;
#(
   parameter int NSRC = 16,
   parameter int NEXT = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [31:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [31:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [NSRC-1:0]   sync_req,
   input  wire logic [NEXT-1:0]   ext_irq,
   input  wire logic              ring_osc,
   input  wire logic              instr_opens_window,
   input  wire logic              instr_is_return_from_irq_instr,
   output      logic              sys_tick,
   output      cpu_cmd_t          cpu_cmd,
   output      logic              wake_stop,
   output      logic              switchback
);
   // ==========================================
   // registers
   logic                 gie_q, slow_q;
   logic [1:0]           cd_q;
   logic [15:0]          prio_lo_q, prio_hi_q, wake_cnt_q, wake_cur_q;
   logic [NEXT-1:0]      ext_en_q, ext_flag_q;
   logic                 wake_en_q, wake_flag_q;
   logic [1:0]           ips_q, lvl_q;
   logic [3:0]           src_q;
   disp_state_t          state_q;
   logic [8:0]           div_q;
   logic                 tick;
   logic [NEXT-1:0]      ext_s1_q, ext_s2_q, filt_q, ext_rise;
   logic [NEXT*FILT_LEN-1:0] hist_q;
   logic [2:0]           ring_q;
   logic                 ring_edge;
   logic [NSRC-1:0]      req;
   logic [3:0]           best_src;
   logic [1:0]           best_lvl;
   logic                 best_ok;
   logic                 aw_q, w_q, aw_low_q, wstrb0_q;
   logic [7:0]           awaddr_q;
   logic [31:0]          wdata_q;
   logic                 wr_go, wr_hit;
   logic [31:0]          rd_val;
   logic                 rd_hit;

   // ==========================================
   // functions
   function automatic logic [8:0] div_ratio(input logic slow, input logic [1:0] cd);
      div_ratio = slow ? SLOW_RATIO : (9'h001 << cd);
   endfunction : div_ratio

   function automatic logic [1:0] src_level(input logic [3:0] s,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
      logic [31:0] both;
      both = {hi, lo};
      src_level = both[{s, 1'b0} +: 2];
   endfunction : src_level

   // ==========================================
   // system clock tick from the undivided clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 9'h000;
      end else if (div_q >= div_ratio(slow_q, cd_q) - 9'h001) begin
         div_q <= 9'h000;
      end else begin
         div_q <= div_q + 9'h001;
      end
   end
   assign tick = (div_q >= div_ratio(slow_q, cd_q) - 9'h001);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_tick <= 1'b0;
      end else begin
         sys_tick <= tick;
      end
   end

   // ==========================================
   // external input synchroniser and glitch filter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
         hist_q   <= '0;
         filt_q   <= '0;
      end else begin
         ext_s1_q <= ext_irq;
         ext_s2_q <= ext_s1_q;
         for (int i = 0; i < NEXT; i++) begin
            hist_q[i*FILT_LEN +: FILT_LEN] <=
               {hist_q[i*FILT_LEN +: FILT_LEN-1], ext_s2_q[i]};
            if (&hist_q[i*FILT_LEN +: FILT_LEN]) begin
               filt_q[i] <= 1'b1;
            end else if (~|hist_q[i*FILT_LEN +: FILT_LEN]) begin
               filt_q[i] <= 1'b0;
            end
         end
      end
   end
   // filter runs on aclk, so recognition in system clocks shrinks with ratio
   assign ext_rise = {NEXT{1'b1}} & ~filt_q &
                     {NEXT{1'b1}} & hist_all_ones(hist_q);

   function automatic logic [NEXT-1:0] hist_all_ones(input logic [NEXT*FILT_LEN-1:0] h);
      for (int i = 0; i < NEXT; i++) begin
         hist_all_ones[i] = &h[i*FILT_LEN +: FILT_LEN];
      end
   endfunction : hist_all_ones

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_flag_q <= '0;
      end else begin
         // set wins over a software clear in the same cycle
         ext_flag_q <= (ext_flag_q &
                        ~((wr_go && wr_hit && awaddr_q == OFS_EXT_FLAG) ?
                          wdata_q[NEXT-1:0] : '0)) | ext_rise;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switchback <= 1'b0;
      end else begin
         switchback <= slow_q && |(ext_rise & ext_en_q);
      end
   end

   // ==========================================
   // wake-up timer on the ring oscillator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ring_q <= 3'h0;
      end else begin
         ring_q <= {ring_q[1:0], ring_osc};
      end
   end
   assign ring_edge = ring_q[1] & ~ring_q[2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_cur_q <= 16'h0000;
      end else if (!wake_en_q) begin
         wake_cur_q <= wake_cnt_q;
      end else if (ring_edge) begin
         // no stop input: the count never pauses
         wake_cur_q <= (wake_cur_q <= 16'h0001) ? wake_cnt_q :
                       wake_cur_q - 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_flag_q <= 1'b0;
      end else if (wake_en_q && ring_edge && wake_cur_q == 16'h0001) begin
         wake_flag_q <= 1'b1;
      end else if (wr_go && wr_hit && awaddr_q == OFS_WAKE_CTL && wdata_q[WCTL_FLAG]) begin
         wake_flag_q <= 1'b0;
      end
   end

   // ==========================================
   // request merge and priority pick
   always_comb begin
      req = sync_req;
      req[SRC_EXT]  = req[SRC_EXT] | |(ext_flag_q & ext_en_q);
      req[SRC_WAKE] = req[SRC_WAKE] | (wake_flag_q & wake_en_q);
      for (int i = 0; i < NSRC; i++) begin
         if (i != SRC_PFAIL) begin
            req[i] = req[i] & gie_q;
         end
      end
   end

   always_comb begin
      best_src = 4'h0;
      best_lvl = IPS_IDLE;
      best_ok  = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (req[i] && src_level(4'(i), prio_lo_q, prio_hi_q) < best_lvl) begin
            best_src = 4'(i);
            best_lvl = src_level(4'(i), prio_lo_q, prio_hi_q);
            best_ok  = 1'b1;
         end
      end
      best_ok = best_ok && (best_lvl < ips_q);
   end

   // ==========================================
   // dispatch towards the core
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         src_q   <= 4'h0;
         lvl_q   <= IPS_IDLE;
      end else if (tick) begin
         unique case (state_q)
            ST_IDLE: begin
               if (best_ok && !instr_is_return_from_irq_instr) begin
                  src_q   <= best_src;
                  lvl_q   <= best_lvl;
                  state_q <= instr_opens_window ? ST_HOLD : ST_STALL;
               end
            end
            ST_HOLD:  state_q <= ST_STALL;
            ST_STALL: state_q <= ST_VEC;
            ST_VEC:   state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ips_q <= IPS_IDLE;
      end else if (tick && state_q == ST_VEC) begin
         ips_q <= lvl_q;
      end else if (tick && instr_is_return_from_irq_instr && state_q == ST_IDLE) begin
         ips_q <= IPS_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_cmd <= '0;
      end else begin
         cpu_cmd.fetch_cancel  <= tick && state_q == ST_VEC;
         cpu_cmd.push          <= tick && state_q == ST_VEC;
         cpu_cmd.ip_load       <= tick && (state_q == ST_VEC ||
                                  (instr_is_return_from_irq_instr && state_q == ST_IDLE));
         cpu_cmd.vector        <= VECTOR_BASE +
                                  (16'(src_q) << VEC_STRIDE_SH);
         cpu_cmd.pop           <= tick && instr_is_return_from_irq_instr && state_q == ST_IDLE;
         cpu_cmd.ip_from_stack <= tick && instr_is_return_from_irq_instr && state_q == ST_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_stop <= 1'b0;
      end else begin
         wake_stop <= tick && state_q == ST_VEC && src_q == 4'(SRC_WAKE);
      end
   end

   // ==========================================
   // AXI4-Lite write channel
   assign wr_go  = aw_q && w_q && !s_axi_bvalid;
   assign wr_hit = aw_low_q && (awaddr_q <= OFS_VEC_BASE) && (awaddr_q[1:0] == 2'b00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         aw_low_q <= 1'b0;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr[7:0];
            aw_low_q <= (s_axi_awaddr[31:8] == 24'h000000);
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q      <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gie_q      <= 1'b0;
         slow_q     <= 1'b0;
         cd_q       <= 2'h0;
         prio_lo_q  <= 16'h0000;
         prio_hi_q  <= 16'h0000;
         ext_en_q   <= '0;
         wake_en_q  <= 1'b0;
         wake_cnt_q <= 16'h0000;
      end else begin
         if (switchback) begin
            slow_q <= 1'b0;
         end
         if (wr_go && wr_hit) begin
            unique case (awaddr_q)
               OFS_CTRL: begin
                  if (wstrb0_q) begin
                     gie_q  <= wdata_q[CTRL_GIE];
                     slow_q <= wdata_q[CTRL_SLOW];
                     cd_q   <= wdata_q[CTRL_CD_LSB +: 2];
                  end
               end
               OFS_PRIO_LOW:  prio_lo_q  <= wdata_q[15:0];
               OFS_PRIO_HIGH: prio_hi_q  <= wdata_q[15:0];
               OFS_EXT_EN:    ext_en_q   <= wdata_q[NEXT-1:0];
               OFS_WAKE_CTL:  wake_en_q  <= wdata_q[WCTL_EN];
               OFS_WAKE_CNT:  wake_cnt_q <= wdata_q[15:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // AXI4-Lite read channel
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr[7:0])
         OFS_CTRL:      rd_val = {28'h0, cd_q, slow_q, gie_q};
         OFS_PRIO_LOW:  rd_val = {16'h0, prio_lo_q};
         OFS_PRIO_HIGH: rd_val = {16'h0, prio_hi_q};
         OFS_EXT_EN:    rd_val[NEXT-1:0] = ext_en_q;
         OFS_EXT_FLAG:  rd_val[NEXT-1:0] = ext_flag_q;
         OFS_WAKE_CTL:  rd_val = {30'h0, wake_flag_q, wake_en_q};
         OFS_WAKE_CNT:  rd_val = {16'h0, wake_cnt_q};
         OFS_STATUS:    rd_val = {16'h0, wake_cur_q[11:0], src_q[1:0], ips_q};
         OFS_VEC_BASE:  rd_val = {16'h0, VECTOR_BASE};
         default:       rd_hit = 1'b0;
      endcase
      if (s_axi_araddr[31:8] != 24'h0) begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_hit ? rd_val : 32'h0000_0000;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : irq_handler

// [sim/cpu_model.sv]
// Purpose: processor core stand-in on the handler's cpu side
// Assumes: system clock ratio 1, one-cycle instructions
// Notes:   keeps a return-address stack
`timescale 1ns/100ps
module cpu_model
   import irq_pkg::*;
(
   input  wire logic     aclk,
   input  wire cpu_cmd_t cpu_cmd,
   input  wire logic     return_from_irq_instr_go,
   input  wire logic     win_go,
   output      logic     instr_is_return_from_irq_instr = 1'h0,
   output      logic     instr_opens_window = 1'h0,
   output      int       depth = 0
);
   logic [15:0] stk[$];
   logic [15:0] pc = 16'h0100;
   // ======
   // one-cycle instructions and stack
   always @(posedge aclk) begin
      instr_is_return_from_irq_instr      <= return_from_irq_instr_go;
      instr_opens_window <= win_go;
      pc                 <= pc + 16'h0001;
      if (cpu_cmd.push) stk.push_back(pc);
      if (cpu_cmd.pop && stk.size() > 0) pc <= stk.pop_back();
      else if (cpu_cmd.ip_load) pc <= cpu_cmd.vector;
      depth <= stk.size();
   end
endmodule : cpu_model

// [sim/irq_handler_props.sv]
// Purpose: concurrent checks on the handler's cpu-side pulses
// Assumes: system clock ratio 1
// Notes:   bound to every handler instance
`timescale 1ns/100ps
module irq_handler_props
   import irq_pkg::*;
#(
   parameter int NSRC = 16,
   parameter int NEXT = 8
) (
   input wire logic     aclk,
   input wire logic     aresetn,
   input wire cpu_cmd_t cpu_cmd,
   input wire logic     instr_is_return_from_irq_instr,
   input wire logic     wake_stop
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ======
   // call and return sequences
   a_call_pulses: assert property (
      cpu_cmd.fetch_cancel |-> cpu_cmd.push && cpu_cmd.ip_load && !cpu_cmd.ip_from_stack)
      else $error("call incomplete");
   a_ip_source: assert property (
      cpu_cmd.ip_load |-> cpu_cmd.push != cpu_cmd.pop) else $error("pointer load unpaired");
   a_vector_slot: assert property (cpu_cmd.fetch_cancel |-> cpu_cmd.vector[2:0] == 3'h0
      && cpu_cmd.vector >= VECTOR_BASE && cpu_cmd.vector <= 16'h0098) else $error("bad vector");
   a_return_pulses: assert property (cpu_cmd.pop |-> cpu_cmd.ip_load
      && cpu_cmd.ip_from_stack && !cpu_cmd.fetch_cancel) else $error("return incomplete");
   a_return_cause: assert property (
      cpu_cmd.pop |-> $past(instr_is_return_from_irq_instr)) else $error("pop without return");
   a_irq_spacing: assert property (
      cpu_cmd.fetch_cancel |=> !cpu_cmd.fetch_cancel [*2]) else $error("calls too close");
   a_return_gap: assert property (
      cpu_cmd.pop |=> !cpu_cmd.fetch_cancel [*2]) else $error("call too soon after return");
   a_wake_vector: assert property (wake_stop |->
      cpu_cmd.vector == VECTOR_BASE + 16'(SRC_WAKE << VEC_STRIDE_SH)) else $error("wake vector");
endmodule : irq_handler_props
bind irq_handler irq_handler_props #(.NSRC(NSRC), .NEXT(NEXT)) irq_handler_props_inst (
   .aclk(aclk), .aresetn(aresetn), .cpu_cmd(cpu_cmd), .instr_is_return_from_irq_instr(instr_is_return_from_irq_instr),
   .wake_stop(wake_stop));

// [sim/testbench.sv]
// Purpose: self-checking bench for the interrupt handler
// Assumes: ratio 1 system clock, ring oscillator of 12 aclk
// Notes:   random levels and requests from a fixed seed
`timescale 1ns/100ps
module testbench import irq_pkg::*;;
   logic        aclk = 1'h0, aresetn = 1'h0, ring_osc = 1'h0, return_from_irq_instr_go = 1'h0, win_go = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rv, rdata, pr;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid, tick, wake_stop, is_return_from_irq_instr, win, sb;
   logic [1:0]  bresp, rresp, rs;
   logic [15:0] sync_req = 16'h0;
   logic [7:0]  ext_irq = 8'h0;
   cpu_cmd_t    cmd;
   int          depth, n_errors = 0, n_checks = 0, cyc = 0, seed = 42, lvl[16], i, n, lat, t1;
   always #4 aclk = ~aclk;
   irq_handler #(.NSRC(16), .NEXT(8)) irq_handler_inst (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sync_req(sync_req), .ext_irq(ext_irq), .ring_osc(ring_osc), .instr_opens_window(win),
      .instr_is_return_from_irq_instr(is_return_from_irq_instr), .sys_tick(tick), .cpu_cmd(cmd), .wake_stop(wake_stop),
      .switchback(sb));
   cpu_model cpu_model_inst (.aclk(aclk), .cpu_cmd(cmd), .return_from_irq_instr_go(return_from_irq_instr_go), .win_go(win_go),
      .instr_is_return_from_irq_instr(is_return_from_irq_instr), .instr_opens_window(win), .depth(depth));
   // ======
   // ring oscillator and hang limit
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc % 6 == 5) ring_osc <= ~ring_osc;
      if (cyc == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end
   // ======
   // helpers
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!bvalid) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      rs = bresp;
      bready <= 1'h0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!rvalid) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end
      rv = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask : axr
   task automatic wait_cmd(input bit want_pop, output int c);
      for (c = 1; c < 60; c++) begin
         @(posedge aclk);
         if (want_pop ? cmd.pop === 1'h1 : cmd.fetch_cancel === 1'h1) break;
      end
   endtask : wait_cmd
   task automatic return_from_irq_instr();
      return_from_irq_instr_go <= 1'h1;
      @(posedge aclk);
      return_from_irq_instr_go <= 1'h0;
      wait_cmd(1, n);
   endtask : return_from_irq_instr
   // reference choice: lowest level, then lowest source number
   function automatic int pick(logic [15:0] req, bit gie);
      int b = -1;
      for (int s = 15; s >= 0; s--)
         if (req[s] && (gie || s == SRC_PFAIL) && (b < 0 || lvl[s] <= lvl[b])) b = s;
      return b;
   endfunction : pick
   task automatic svc(input logic [15:0] req, input bit gie, input bit w);
      int s = pick(req, gie);
      win_go <= w;
      @(posedge aclk);
      sync_req <= req;
      win_go <= 1'h0;
      @(posedge aclk);
      wait_cmd(0, n);
      lat = n + 1;
      if (s < 0) begin
         chk("call absent", 32'h1, {31'h0, n == 60});
         sync_req <= 16'h0;
      end else begin
         chk("vector", {16'h0, VECTOR_BASE + 16'(s * 8)}, {16'h0, cmd.vector});
         axr(OFS_STATUS);
         chk("active level", 32'(lvl[s]), {30'h0, rv[1:0]});
         return_from_irq_instr();
         wait_cmd(0, n);
         chk("reentry gap", 32'h1, {31'h0, n >= 3 && n < 60});
         sync_req <= 16'h0;
         return_from_irq_instr();
         axr(OFS_STATUS);
         chk("idle level", {30'h0, IPS_IDLE}, {30'h0, rv[1:0]});
      end
   endtask : svc
   // ======
   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      axr(OFS_CTRL);
      chk("control reset", 32'h0, rv);
      axw(OFS_VEC_BASE, 32'hffffffff);
      axr(OFS_VEC_BASE);
      chk("vector base", {16'h0, VECTOR_BASE}, rv);
      axr(8'h40);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      $display("test registers done");
      for (i = 0; i < 8; i++) begin
         for (int s = 0; s < 16; s++) begin
            lvl[s] = {$random(seed)} % 3;
            pr[2*s +: 2] = 2'(lvl[s]);
         end
         axw(OFS_PRIO_LOW, {16'h0, pr[15:0]});
         axw(OFS_PRIO_HIGH, {16'h0, pr[31:16]});
         axw(OFS_CTRL, {31'h0, i % 4 != 0});
         svc(16'($random(seed) & $random(seed)), i % 4 != 0, 1'h0);
      end
      $display("test random service done");
      svc(16'h0002, 1'h1, 1'h0);
      chk("call latency", 32'h4, 32'(lat));
      svc(16'h0002, 1'h1, 1'h1);
      chk("window latency", 32'h5, 32'(lat));
      $display("test window done");
      ext_irq <= 8'h01;
      repeat (2) @(posedge aclk);
      ext_irq <= 8'h00;
      repeat (8) @(posedge aclk);
      axr(OFS_EXT_FLAG);
      chk("short pulse", 32'h0, rv);
      ext_irq <= 8'h10;
      repeat (6) @(posedge aclk);
      ext_irq <= 8'h00;
      repeat (8) @(posedge aclk);
      axr(OFS_EXT_FLAG);
      chk("flag while off", 32'h10, rv);
      axw(OFS_EXT_EN, 32'h10);
      wait_cmd(0, n);
      chk("external vector", 32'h30, {16'h0, cmd.vector});
      axw(OFS_EXT_FLAG, 32'h10);
      return_from_irq_instr();
      $display("test external done");
      axw(OFS_WAKE_CNT, 32'h3);
      axw(OFS_WAKE_CTL, 32'h1);
      for (n = 0; n < 300 && wake_stop !== 1'h1; n++) @(posedge aclk);
      t1 = cyc;
      axw(OFS_WAKE_CTL, 32'h3);
      return_from_irq_instr();
      for (n = 0; n < 300 && wake_stop !== 1'h1; n++) @(posedge aclk);
      chk("wake period", 32'h24, 32'(cyc - t1));
      axw(OFS_WAKE_CTL, 32'h2);
      return_from_irq_instr();
      @(posedge aclk);
      chk("stack depth", 32'h0, 32'(depth));
      $display("test wake done");
      axw(8'h44, 32'h0);
      chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      axw(OFS_CTRL, 32'h8);
      n = 0;
      repeat (32) begin
         @(posedge aclk);
         if (tick === 1'h1) n++;
      end
      chk("tick ratio", 32'h8, 32'(n));
      axw(OFS_CTRL, 32'h2);
      ext_irq <= 8'h10;
      for (n = 0; n < 20 && sb !== 1'h1; n++) @(posedge aclk);
      ext_irq <= 8'h00;
      chk("switchback", 32'h1, {31'h0, n < 20});
      axr(OFS_CTRL);
      chk("slow cleared", 32'h0, rv);
      $display("test clock done");
      report_and_stop();
   end
endmodule : testbench
